// *** core/ptu_pkg.sv ***
// Package of constants and types for the periodic timer capture block.
package ptu_pkg;

  // ----------------------------------------------------------------
  // Widths and counter limits.
  // ----------------------------------------------------------------
  localparam int CNT_W = 10;
  localparam logic [9:0] CNT_MAX = 10'h3FF;
  localparam logic [9:0] CNT_ZERO = 10'h000;
  localparam logic [7:0] DATA_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // Register indices on the plain register port.
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL0 = 4'h0;
  localparam logic [3:0] REG_CTRL1 = 4'h1;
  localparam logic [3:0] REG_COMPARE_REGISTER_A_LO = 4'h2;
  localparam logic [3:0] REG_COMPARE_REGISTER_A_HI = 4'h3;
  localparam logic [3:0] REG_PERIOD_REGISTER_LO = 4'h4;
  localparam logic [3:0] REG_PERIOD_REGISTER_HI = 4'h5;
  localparam logic [3:0] REG_CNT_LO = 4'h6;
  localparam logic [3:0] REG_CNT_HI = 4'h7;
  localparam logic [3:0] REG_IRQ_STAT = 4'h8;
  localparam logic [3:0] REG_IRQ_MASK = 4'h9;

  // ----------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------
  // Control 0: bit0 run, bit1 capture source select.
  localparam int BIT_RUN = 0;
  localparam int BIT_CAPTS = 1;
  // Control 1: [7:6] mode, [5:4] edge/output select, 3 out init,
  // 2 polarity invert, 0 counter clear select.
  localparam int BIT_MODE_HI = 7;
  localparam int BIT_MODE_LO = 6;
  localparam int BIT_IO_HI = 5;
  localparam int BIT_IO_LO = 4;
  localparam int BIT_OC = 3;
  localparam int BIT_POL = 2;
  localparam int BIT_CCLR = 0;
  // Interrupt status: bit0 capture/A match, bit1 period match.
  localparam int BIT_IRQ_A = 0;
  localparam int BIT_IRQ_P = 1;
  localparam logic [7:0] RESET_CTRL = 8'h00;
  localparam logic [1:0] IRQ_W0 = 2'h0;

  // ----------------------------------------------------------------
  // Mode and edge encodings.
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_COMPARE = 2'h0;
  localparam logic [1:0] MODE_CAPTURE = 2'h1;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TIMER = 2'h3;
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  localparam logic [1:0] EDGE_NONE = 2'h3;

  typedef enum logic [1:0] {
    PTU_IDLE,
    PTU_CAPTURE,
    PTU_PULSE
  } ptu_state_t;

endpackage : ptu_pkg

// *** core/ptu_sync.sv ***
// Two-stage synchroniser with edge detection for the capture pin.
`timescale 1ns/1ps
module ptu_sync import ptu_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire logic pinIn,
  output logic rise,
  output logic fall
);

  // ----------------------------------------------------------------
  // Synchroniser and edge detector.
  // ----------------------------------------------------------------
  logic meta;
  logic syncd;
  logic last;

  // The first stage feeds only the second; edges look at later stages.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta <= 1'b0;
      syncd <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= pinIn;
      syncd <= meta;
      last <= syncd;
    end
  end

  // One pulse per synchronised transition.
  assign rise = syncd & ~last;
  assign fall = ~syncd & last;

  chk_one_edge: assert property (@(posedge clk) disable iff (!nrst)
    rise |=> !rise) else $error("rise pulse longer than one cycle");

endmodule : ptu_sync

// *** core/ptu_counter.sv ***
// Ten-bit up counter with period wrap for the periodic timer.
`timescale 1ns/1ps
module ptu_counter import ptu_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire logic run,
  input wire logic restart,
  input wire logic [CNT_W-1:0] period,
  input wire logic periodUsed,
  output logic [CNT_W-1:0] count,
  output logic periodMatch
);

  // ----------------------------------------------------------------
  // Counter.
  // ----------------------------------------------------------------
  // A zero period means the full range is used before wrapping.
  assign periodMatch = run && periodUsed &&
                       (period == CNT_ZERO ? count == CNT_MAX
                                           : count == period);

  // Increment while running, clear on period match or a fresh start.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count <= CNT_ZERO;
    end else if (restart) begin
      count <= CNT_ZERO;
    end else if (periodMatch) begin
      count <= CNT_ZERO;
    end else if (run) begin
      count <= count + 10'h001;
    end
  end

  chk_hold_stop: assert property (@(posedge clk) disable iff (!nrst)
    !run && !restart |=> $stable(count))
    else $error("counter moved while stopped");

endmodule : ptu_counter

// *** core/ptu_timer.sv ***
// Periodic timer unit: capture input mode and single pulse trigger.
//
// How it works
// - Mode field pattern 01 selects capture operation.
// - Capture source select bit picks the external capture pin.
// - Edge field picks rising, falling or both edges as active.
// - Counter starts only on a low to high move of run bit.
// - Active edge copies counter into compare A and raises interrupt.
// - Counter runs regardless of capture pin until run bit falls.
// - Period match clears the counter to zero.
// - Period match also raises the timer interrupt.
// - Edge field 11 disables capture; counter keeps running.
// - Clear select, initial state and polarity bits ignored in capture.
// - Period zero lets the counter run to full count.
// - Pin is watched even when driven as an output.
// - Single pulse: either pin edge sets the run bit.
// - Software may also start a single pulse via run bit.
// - Counter is ten bits and overflows after 3FF.
// - Single pulse: compare A match clears the run bit.
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module ptu_timer import ptu_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  input wire logic capture_input_pin,
  output logic irq
);

  // ----------------------------------------------------------------
  // Control registers.
  // ----------------------------------------------------------------
  logic counter_run_bit;
  logic capture_source_select;
  logic mode_select_hi;
  logic mode_select_lo;
  logic edge_output_select_hi;
  logic edge_output_select_lo;
  logic output_initial_state;
  logic output_polarity_invert;
  logic counter_clear_select;
  logic [CNT_W-1:0] compare_register_a;
  logic [CNT_W-1:0] period_register;
  logic [1:0] irqStatus;
  logic [1:0] irqMask;
  logic runLast;
  logic pinRise;
  logic pinFall;
  logic [CNT_W-1:0] count;
  logic periodMatch;
  logic [1:0] mode;
  logic [1:0] edgeSel;
  logic isCapture;
  logic isPulse;
  logic activeEdge;
  logic pulseEdge;
  logic captureHit;
  logic compareHit;
  logic runStart;
  logic [1:0] irqSet;
  ptu_state_t state;

  assign mode = {mode_select_hi, mode_select_lo};
  assign edgeSel = {edge_output_select_hi, edge_output_select_lo};

  // Decodes whether a write of the given index is happening now.
  function automatic logic wrHit(input logic [3:0] idx,
                                 input logic [3:0] addr,
                                 input logic we);
    wrHit = we && (addr == idx);
  endfunction : wrHit

  // ----------------------------------------------------------------
  // Capture pin and edge qualification.
  // ----------------------------------------------------------------
  // The pin is sampled whatever its direction, so self-driven
  // transitions on a shared pin still capture.
  ptu_sync u_sync (
    .clk(clk),
    .nrst(nrst),
    .pinIn(capture_input_pin),
    .rise(pinRise),
    .fall(pinFall)
  );

  // Edge field chooses which transitions count; 11 selects none.
  always_comb begin
    case (edgeSel)
      EDGE_RISE: activeEdge = pinRise;
      EDGE_FALL: activeEdge = pinFall;
      EDGE_BOTH: activeEdge = pinRise | pinFall;
      EDGE_NONE: activeEdge = 1'b0;
      default: activeEdge = 1'b0;
    endcase
  end

  // Single pulse holds the edge field at 11, which selects no capture
  // edge, so the pulse trigger takes either pin transition instead.
  assign isCapture = (mode == MODE_CAPTURE);
  assign isPulse = (mode == MODE_PWM) && (edgeSel == EDGE_NONE);
  assign pulseEdge = pinRise | pinFall;
  assign captureHit = isCapture && capture_source_select &&
                      counter_run_bit && activeEdge;
  // The start cycle still shows the count left by the last pulse, so a
  // match there must not end the new pulse at once.
  assign compareHit = isPulse && counter_run_bit && !runStart &&
                      (count == compare_register_a);
  assign runStart = counter_run_bit && !runLast;

  // ----------------------------------------------------------------
  // Counter instance.
  // ----------------------------------------------------------------
  // Counting only follows the run bit, never the capture pin.
  ptu_counter u_cnt (
    .clk(clk),
    .nrst(nrst),
    .run(counter_run_bit),
    .restart(runStart),
    .period(period_register),
    .periodUsed(!isPulse),
    .count(count),
    .periodMatch(periodMatch)
  );

  // ----------------------------------------------------------------
  // Mode tracking state.
  // ----------------------------------------------------------------
  // Tracks which operation the unit is in, for status read-back.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= PTU_IDLE;
    end else begin
      case (1'b1)
        isCapture: state <= PTU_CAPTURE;
        isPulse: state <= PTU_PULSE;
        default: state <= PTU_IDLE;
      endcase
    end
  end

  // Edge detector for the run bit.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      runLast <= 1'b0;
    end else begin
      runLast <= counter_run_bit;
    end
  end

  // ----------------------------------------------------------------
  // Run bit and control 0.
  // ----------------------------------------------------------------
  // A pin edge or software sets run in single pulse; an A match
  // clears it. Hardware set wins over a software clear.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      counter_run_bit <= 1'b0;
      capture_source_select <= 1'b0;
    end else begin
      if (wrHit(REG_CTRL0, regAddr, regWrite)) begin
        counter_run_bit <= regWdata[BIT_RUN];
        capture_source_select <= regWdata[BIT_CAPTS];
      end else if (compareHit) begin
        counter_run_bit <= 1'b0;
      end
      if (isPulse && !counter_run_bit && pulseEdge) begin
        counter_run_bit <= 1'b1;
      end
    end
  end

  // Control 1 holds mode and the output bits; the output bits steer
  // nothing here since capture operation has no output.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {mode_select_hi, mode_select_lo} <= MODE_COMPARE;
      {edge_output_select_hi, edge_output_select_lo} <= EDGE_RISE;
      output_initial_state <= 1'b0;
      output_polarity_invert <= 1'b0;
      counter_clear_select <= 1'b0;
    end else if (wrHit(REG_CTRL1, regAddr, regWrite)) begin
      mode_select_hi <= regWdata[BIT_MODE_HI];
      mode_select_lo <= regWdata[BIT_MODE_LO];
      edge_output_select_hi <= regWdata[BIT_IO_HI];
      edge_output_select_lo <= regWdata[BIT_IO_LO];
      output_initial_state <= regWdata[BIT_OC];
      output_polarity_invert <= regWdata[BIT_POL];
      counter_clear_select <= regWdata[BIT_CCLR];
    end
  end

  // ----------------------------------------------------------------
  // Compare and period registers.
  // ----------------------------------------------------------------
  // A capture overwrites compare A; it wins over a same-cycle write.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      compare_register_a <= CNT_ZERO;
    end else if (captureHit) begin
      compare_register_a <= count;
    end else if (wrHit(REG_COMPARE_REGISTER_A_LO, regAddr, regWrite)) begin
      compare_register_a[7:0] <= regWdata;
    end else if (wrHit(REG_COMPARE_REGISTER_A_HI, regAddr, regWrite)) begin
      compare_register_a[9:8] <= regWdata[1:0];
    end
  end

  // Period register, low and high parts.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      period_register <= CNT_ZERO;
    end else if (wrHit(REG_PERIOD_REGISTER_LO, regAddr, regWrite)) begin
      period_register[7:0] <= regWdata;
    end else if (wrHit(REG_PERIOD_REGISTER_HI, regAddr, regWrite)) begin
      period_register[9:8] <= regWdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Interrupts.
  // ----------------------------------------------------------------
  // Capture or A match sets bit 0; period match in capture sets bit 1.
  assign irqSet[BIT_IRQ_A] = captureHit | compareHit;
  assign irqSet[BIT_IRQ_P] = periodMatch && isCapture;

  // A read of status clears it, but a new event in that cycle stays.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irqStatus <= IRQ_W0;
    end else if (regRead && regAddr == REG_IRQ_STAT) begin
      irqStatus <= irqSet;
    end else begin
      irqStatus <= irqStatus | irqSet;
    end
  end

  // Mask register.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irqMask <= IRQ_W0;
    end else if (wrHit(REG_IRQ_MASK, regAddr, regWrite)) begin
      irqMask <= regWdata[1:0];
    end
  end

  assign irq = |(irqStatus & irqMask);

  // ----------------------------------------------------------------
  // Read port.
  // ----------------------------------------------------------------
  // Read data stands for the single cycle after the read strobe.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      regRdata <= DATA_ZERO;
    end else if (!regRead) begin
      regRdata <= DATA_ZERO;
    end else begin
      case (regAddr)
        REG_CTRL0: regRdata <= {4'h0, 2'(state), capture_source_select,
                                counter_run_bit};
        REG_CTRL1: regRdata <= {mode, edgeSel, output_initial_state,
                                output_polarity_invert, 1'b0,
                                counter_clear_select};
        REG_COMPARE_REGISTER_A_LO: regRdata <= compare_register_a[7:0];
        REG_COMPARE_REGISTER_A_HI: regRdata <= {6'h00, compare_register_a[9:8]};
        REG_PERIOD_REGISTER_LO: regRdata <= period_register[7:0];
        REG_PERIOD_REGISTER_HI: regRdata <= {6'h00, period_register[9:8]};
        REG_CNT_LO: regRdata <= count[7:0];
        REG_CNT_HI: regRdata <= {6'h00, count[9:8]};
        REG_IRQ_STAT: regRdata <= {6'h00, irqStatus};
        REG_IRQ_MASK: regRdata <= {6'h00, irqMask};
        default: regRdata <= DATA_ZERO;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  chk_capture_latch: assert property (@(posedge clk) disable iff (!nrst)
    captureHit |=> compare_register_a == $past(count))
    else $error("compare A did not latch the count");

  chk_capture_irq: assert property (@(posedge clk) disable iff (!nrst)
    captureHit |=> irqStatus[BIT_IRQ_A])
    else $error("capture did not set interrupt");

  chk_none_edge: assert property (@(posedge clk) disable iff (!nrst)
    edgeSel == EDGE_NONE |-> !captureHit)
    else $error("capture with edges disabled");

  chk_period_wrap: assert property (@(posedge clk) disable iff (!nrst)
    periodMatch && !runStart |=> count == CNT_ZERO)
    else $error("counter not cleared on period match");

  chk_period_irq: assert property (@(posedge clk) disable iff (!nrst)
    periodMatch && isCapture |=> irqStatus[BIT_IRQ_P])
    else $error("period match did not set interrupt");

  chk_start_zero: assert property (@(posedge clk) disable iff (!nrst)
    runStart |=> count == CNT_ZERO)
    else $error("counter not restarted from zero");

  chk_run_keeps: assert property (@(posedge clk) disable iff (!nrst)
    isCapture && counter_run_bit && !periodMatch && !runStart
    |=> count == $past(count) + 10'h001)
    else $error("counter stalled in capture mode");

  chk_pulse_stop: assert property (@(posedge clk) disable iff (!nrst)
    compareHit && !regWrite |=> !counter_run_bit)
    else $error("compare A match did not stop pulse");

  chk_pulse_trig: assert property (@(posedge clk) disable iff (!nrst)
    isPulse && !counter_run_bit && pulseEdge |=> counter_run_bit)
    else $error("pin edge did not start pulse");

  chk_pulse_start: assert property (@(posedge clk) disable iff (!nrst)
    isPulse && runStart && !regWrite |=> counter_run_bit)
    else $error("single pulse stopped at its start");

  chk_full_range: assert property (@(posedge clk) disable iff (!nrst)
    !isPulse && counter_run_bit && !runStart && !regWrite &&
    period_register == CNT_ZERO
    |=> (count == CNT_ZERO) == ($past(count) == CNT_MAX))
    else $error("zero period did not wrap at full count");

  chk_a_holds: assert property (@(posedge clk) disable iff (!nrst)
    !captureHit && !regWrite |=> $stable(compare_register_a))
    else $error("compare A changed without capture or write");

endmodule : ptu_timer

// *** sim/ptu_pin_src.sv ***
// Behavioural source that drives the capture pin from outside.
`timescale 1ns/1ps
module ptu_pin_src (
  input wire logic clk,
  input wire logic nrst,
  input wire logic go,
  input wire logic [7:0] width,
  output logic capturePin
);
  // ----------------------------------------------------------------
  // Pulse generator.
  // ----------------------------------------------------------------
  logic [7:0] left;

  // One request gives a rising edge, then a falling edge after width
  // cycles, so both active edge kinds can be offered to the block.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      left <= 8'h00;
      capturePin <= 1'b0;
    end else if (go) begin
      left <= width;
      capturePin <= 1'b1;
    end else if (left > 8'h01) begin
      left <= left - 8'h01;
    end else begin
      left <= 8'h00;
      capturePin <= 1'b0;
    end
  end
endmodule : ptu_pin_src

// *** sim/ptu_timer_tb_top.sv ***
// Self-checking testbench for the periodic timer capture block.
`timescale 1ns/1ps
module ptu_timer_tb_top;
  import ptu_pkg::*;

  // ----------------------------------------------------------------
  // Signals and counters.
  // ----------------------------------------------------------------
  logic clk, nrst, regWrite, regRead, go, irq, pin;
  logic [3:0] regAddr;
  logic [7:0] regWdata, regRdata, width, rv, c0;
  int fails, comparisons;

  ptu_timer dut (.clk(clk), .nrst(nrst), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .capture_input_pin(pin), .irq(irq));

  ptu_pin_src src (.clk(clk), .nrst(nrst), .go(go), .width(width),
    .capturePin(pin));

  // Clock of 40 ns period.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test;
    if (fails == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so they are
  // sampled on the falling edge of that cycle.
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    rv = regRdata;
  endtask : rd

  task automatic pulse(input logic [7:0] w);
    @(posedge clk);
    go <= 1'b1;
    width <= w;
    @(posedge clk);
    go <= 1'b0;
  endtask : pulse

  // ----------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd(REG_CTRL0);
    check(rv, 16'h0000);
    rd(REG_CTRL1);
    check(rv, 16'h0000);
    idle(5);
    rd(REG_CNT_LO);
    check(rv, 16'h0000);
    rd(REG_IRQ_STAT);
    check(rv, 16'h0000);
    wr(4'hF, 8'h5A);
    rd(4'hF);
    check(rv, 16'h0000);
    check(irq, 1'b0);
  endtask : t_reset

  // Capture of the running count, interrupt, and source select off.
  task automatic t_capture;
    wr(REG_IRQ_MASK, 8'h01);
    wr(REG_CTRL1, 8'h40);
    wr(REG_CTRL0, 8'h03);
    idle(3);
    rd(REG_CNT_LO);
    c0 = rv;
    pulse(8'h14);
    idle(10);
    @(negedge clk);
    check(irq, 1'b1);
    rd(REG_COMPARE_REGISTER_A_HI);
    check(rv, 16'h0000);
    rd(REG_COMPARE_REGISTER_A_LO);
    check(rv - c0 >= 8'h03 && rv - c0 <= 8'h0E, 1'b1);
    rd(REG_IRQ_STAT);
    check(rv, 16'h0001);
    @(negedge clk);
    check(irq, 1'b0);
    idle(20);
    rd(REG_IRQ_STAT);
    wr(REG_CTRL0, 8'h01);
    pulse(8'h06);
    idle(12);
    rd(REG_IRQ_STAT);
    check(rv, 16'h0000);
  endtask : t_capture

  // Every edge code, with the unused output bits set high.
  task automatic t_edges;
    logic [1:0] e;
    for (int i = 0; i < 4; i++) begin
      e = i[1:0];
      wr(REG_CTRL1, 8'h4D | {2'b00, e, 4'h0});
      wr(REG_CTRL0, 8'h03);
      idle(4);
      rd(REG_IRQ_STAT);
      pulse(8'h0C);
      idle(6);
      rd(REG_IRQ_STAT);
      check(rv[0], e == EDGE_RISE || e == EDGE_BOTH);
      idle(12);
      rd(REG_IRQ_STAT);
      check(rv[0], e == EDGE_FALL || e == EDGE_BOTH);
    end
  endtask : t_edges

  task automatic t_period;
    wr(REG_CTRL0, 8'h00);
    wr(REG_PERIOD_REGISTER_LO, 8'h05);
    wr(REG_PERIOD_REGISTER_HI, 8'h00);
    wr(REG_CTRL1, 8'h40);
    rd(REG_IRQ_STAT);
    wr(REG_CTRL0, 8'h03);
    for (int i = 0; i < 12; i++) begin
      rd(REG_CNT_LO);
      check(rv <= 8'h05, 1'b1);
    end
    rd(REG_IRQ_STAT);
    check(rv[BIT_IRQ_P], 1'b1);
  endtask : t_period

  // Period zero runs to the top of the ten-bit range, then stops hold.
  task automatic t_full;
    logic [7:0] a;
    wr(REG_CTRL0, 8'h00);
    wr(REG_PERIOD_REGISTER_LO, 8'h00);
    wr(REG_CTRL0, 8'h03);
    idle(1000);
    rd(REG_CNT_HI);
    check(rv, 16'h0003);
    idle(40);
    rd(REG_CNT_HI);
    check(rv, 16'h0000);
    wr(REG_CTRL0, 8'h02);
    rd(REG_CNT_LO);
    a = rv;
    idle(5);
    rd(REG_CNT_LO);
    check(rv, a);
  endtask : t_full

  // Single pulse, started by the pin and then by software.
  task automatic t_pulse;
    wr(REG_COMPARE_REGISTER_A_LO, 8'h0A);
    wr(REG_COMPARE_REGISTER_A_HI, 8'h00);
    wr(REG_CTRL1, 8'hB0);
    wr(REG_CTRL0, 8'h02);
    rd(REG_IRQ_STAT);
    pulse(8'h03);
    idle(6);
    rd(REG_CTRL0);
    check(rv[BIT_RUN], 1'b1);
    idle(20);
    rd(REG_CTRL0);
    check(rv[BIT_RUN], 1'b0);
    rd(REG_IRQ_STAT);
    check(rv[BIT_IRQ_A], 1'b1);
    wr(REG_CTRL0, 8'h03);
    idle(2);
    rd(REG_CTRL0);
    check(rv[BIT_RUN], 1'b1);
    idle(20);
    rd(REG_CTRL0);
    check(rv[BIT_RUN], 1'b0);
  endtask : t_pulse

  // ----------------------------------------------------------------
  // Main sequence and watchdog.
  // ----------------------------------------------------------------
  // Reset is held for four cycles; the first request follows it.
  initial begin
    fails = 0;
    comparisons = 0;
    nrst = 1'b0;
    regAddr = 4'h0;
    regWdata = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    go = 1'b0;
    width = 8'h00;
    idle(4);
    nrst <= 1'b1;
    t_reset();
    t_capture();
    t_edges();
    t_period();
    t_full();
    t_pulse();
    stop_test();
  end

  // The tests need under 1500 cycles; this bound is far above.
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    stop_test();
  end
endmodule : ptu_timer_tb_top
